// ===== design/fbsi_params.svh
// fbsi_params.svh: register map, reset values and timing constants
`ifndef FBSI_PARAMS_SVH
`define FBSI_PARAMS_SVH
//----------------------------------------------------------------------
// Summary of operation
// R1: the on-line lamp is lit only while on the bus with exchange possible.
// R2: the off-line lamp is lit whenever the on-line lamp is dark, dark otherwise.
// R3: the diagnostics lamp is dark unless a bus-side fault is present.
// R4: a data length mismatch blinks the diagnostics lamp at 1 Hz.
// R5: a user parameter mismatch blinks the diagnostics lamp at 2 Hz.
// R6: the bus bit rate is found automatically over 9.6 kbaud to 12 Mbaud.
// R7: the station address is two decimal switch digits, valid 1 to 99.
// R8: process data stays within 200 bytes or a smaller master limit.
// R9: blink periods come from a clock counter; length error wins.
//----------------------------------------------------------------------

//----------------------------------------------------------------------
// register byte addresses
//----------------------------------------------------------------------
`define FBSI_REG_CTRL      8'h00
`define FBSI_REG_LOC_LEN   8'h04
`define FBSI_REG_MST_LEN   8'h08
`define FBSI_REG_LOC_PRM   8'h0c
`define FBSI_REG_MST_PRM   8'h10
`define FBSI_REG_LIMIT     8'h14
`define FBSI_REG_STATUS    8'h18

//----------------------------------------------------------------------
// field positions
//----------------------------------------------------------------------
`define FBSI_CTRL_EXCH     0
`define FBSI_LEN_IN_LSB    0
`define FBSI_LEN_OUT_LSB   8
`define FBSI_ST_ONLINE     0
`define FBSI_ST_OFFLINE    1
`define FBSI_ST_DIAG       2
`define FBSI_ST_CFG_ERR    3
`define FBSI_ST_PRM_ERR    4
`define FBSI_ST_ADDR_OK    5
`define FBSI_ST_LOCKED     6
`define FBSI_ST_RATE_LSB   8
`define FBSI_ST_ADDR_LSB   16

//----------------------------------------------------------------------
// reset values and limits
//----------------------------------------------------------------------
`define FBSI_RST_LIMIT     8'hc8
`define FBSI_MAX_BYTES     8'hc8
`define FBSI_ADDR_MIN      7'h01
`define FBSI_ADDR_MAX      7'h63
`define FBSI_DIGIT_MAX     4'h9

//----------------------------------------------------------------------
// timing
//----------------------------------------------------------------------
`define FBSI_CLK_KHZ       40000
`define FBSI_HALF_1HZ_MS   500
`define FBSI_HALF_2HZ_MS   250
`define FBSI_PULSES_GROUP  4'hf
// shortest low run per bit-rate band, in clock cycles
`define FBSI_THR_0         13'h0b86
`define FBSI_THR_1         13'h0546
`define FBSI_THR_2         13'h0262
`define FBSI_THR_3         13'h012c
`define FBSI_THR_4         13'h0082
`define FBSI_THR_5         13'h002e
`define FBSI_THR_6         13'h0013
`define FBSI_THR_7         13'h000a
`define FBSI_THR_8         13'h0005

`endif

// ===== design/fbsi_pkg.sv
// fbsi_pkg.sv: state types of the status indicator block
package fbsi_pkg;

  typedef enum logic [2:0] {
    FBSI_M_IDLE = 3'b001,
    FBSI_M_CFG  = 3'b010,
    FBSI_M_PRM  = 3'b100
  } fbsi_mode_e;

  typedef struct packed {
    logic        rx_s1;
    logic        rx_s2;
    logic        rx_d;
    logic [12:0] run;
    logic [12:0] grp_min;
    logic [3:0]  pulses;
    logic [3:0]  idx;
    logic        locked;
  } fbsi_rate_s;

  typedef struct packed {
    logic        act_s1;
    logic        act_s2;
    logic [7:0]  sw_s1;
    logic [7:0]  sw_s2;
    logic        exch_en;
    logic [7:0]  loc_in;
    logic [7:0]  loc_out;
    logic [7:0]  mst_in;
    logic [7:0]  mst_out;
    logic [15:0] loc_prm;
    logic [15:0] mst_prm;
    logic [7:0]  limit;
    logic        cfg_err;
    logic        prm_err;
    logic        addr_valid;
    logic [6:0]  station;
    logic        online;
    logic        offline;
    fbsi_mode_e  mode;
    logic [24:0] cnt;
    logic        diag;
    logic [31:0] rdata;
  } fbsi_top_s;

endpackage

// ===== design/fbsi_rate_detect.sv
// fbsi_rate_detect.sv: automatic bus bit-rate detection
`timescale 1ns/100ps
`include "fbsi_params.svh"
module fbsi_rate_detect (
  input  wire logic       core_clk_in,    // system clock
  input  wire logic       rst_in,         // async reset, high
  input  wire logic       bus_rx_in,      // bus receive pin
  output logic [3:0]      rate_idx_out,   // 0 slowest .. 9 fastest
  output logic            rate_locked_out // a rate has been found
);

  fbsi_pkg::fbsi_rate_s s;
  fbsi_pkg::fbsi_rate_s n;
  logic [12:0]          cand;
  logic                 rise;

  //--------------------------------------------------------------------
  // band classification
  //--------------------------------------------------------------------
  function automatic logic [3:0] classify(input logic [12:0] w);
    if (w >= `FBSI_THR_0) return 4'h0;
    else if (w >= `FBSI_THR_1) return 4'h1;
    else if (w >= `FBSI_THR_2) return 4'h2;
    else if (w >= `FBSI_THR_3) return 4'h3;
    else if (w >= `FBSI_THR_4) return 4'h4;
    else if (w >= `FBSI_THR_5) return 4'h5;
    else if (w >= `FBSI_THR_6) return 4'h6;
    else if (w >= `FBSI_THR_7) return 4'h7;
    else if (w >= `FBSI_THR_8) return 4'h8;
    else return 4'h9;
  endfunction

  // shortest low run in a group is one bit time; longer runs are
  // several zero bits in a row
  always_comb begin
    n         = s;
    n.rx_s1   = bus_rx_in;
    n.rx_s2   = s.rx_s1;
    n.rx_d    = s.rx_s2;
    rise      = s.rx_s2 && !s.rx_d;
    cand      = (s.run < s.grp_min) ? s.run : s.grp_min;
    if (!s.rx_s2) begin
      if (s.run != 13'h1fff) begin
        n.run = s.run + 13'h0001;
      end
    end else begin
      n.run = 13'h0000;
    end
    // R6: group of pulses
    if (rise) begin
      if (s.pulses == `FBSI_PULSES_GROUP) begin
        n.idx     = classify(cand);
        n.locked  = 1'b1;
        n.pulses  = 4'h0;
        n.grp_min = 13'h1fff;
      end else begin
        n.pulses  = s.pulses + 4'h1;
        n.grp_min = cand;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '{rx_s1: 1'b1, rx_s2: 1'b1, rx_d: 1'b1, run: 13'h0000,
             grp_min: 13'h1fff, pulses: 4'h0, idx: 4'h0,
             locked: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign rate_idx_out    = s.idx;
  assign rate_locked_out = s.locked;

  property p_rate_fast;
    @(posedge core_clk_in) disable iff (rst_in)
    (rise && s.pulses == `FBSI_PULSES_GROUP && cand < `FBSI_THR_8)
      |=> (rate_idx_out == 4'h9 && rate_locked_out);
  endproperty
  a_rate_fast: assert property (p_rate_fast) // R6
    else $error("fast bit rate not classified as top band");

  property p_rate_slow;
    @(posedge core_clk_in) disable iff (rst_in)
    (rise && s.pulses == `FBSI_PULSES_GROUP && cand >= `FBSI_THR_0)
      |=> (rate_idx_out == 4'h0);
  endproperty
  a_rate_slow: assert property (p_rate_slow) // R6
    else $error("slow bit rate not classified as bottom band");

endmodule // fbsi_rate_detect

// ===== design/fbsi_top.sv
// fbsi_top.sv: fieldbus slave status indicators and configuration
`timescale 1ns/100ps
`include "fbsi_params.svh"
module fbsi_top #(
  parameter int unsigned HALF_1HZ_CYC = `FBSI_HALF_1HZ_MS * `FBSI_CLK_KHZ,
  parameter int unsigned HALF_2HZ_CYC = `FBSI_HALF_2HZ_MS * `FBSI_CLK_KHZ,
  parameter logic [7:0]  MAX_BYTES    = `FBSI_MAX_BYTES
) (
  input  wire logic        core_clk_in,       // system clock, 40 MHz
  input  wire logic        rst_in,            // async reset, high
  input  wire logic        bus_active_in,     // bus engine sees master
  input  wire logic        bus_rx_in,         // bus receive pin
  input  wire logic [3:0]  sw_tens_in,        // rotary switch, tens
  input  wire logic [3:0]  sw_ones_in,        // rotary switch, ones
  input  wire logic [7:0]  addr_in,           // register byte address
  input  wire logic [31:0] wr_data_in,        // register write data
  input  wire logic        wr_stb_in,         // register write strobe
  input  wire logic        rd_stb_in,         // register read strobe
  output logic [31:0]      rd_data_out,       // read data, next cycle
  output logic             online_led_out,    // green on-line lamp
  output logic             offline_led_out,   // red off-line lamp
  output logic             diag_led_out,      // red diagnostics lamp
  output logic [6:0]       station_addr_out,  // binary station address
  output logic             addr_valid_out,    // station address usable
  output logic [3:0]       rate_idx_out,      // detected bit-rate band
  output logic             rate_locked_out    // bit rate detected
);

  fbsi_pkg::fbsi_top_s  s;
  fbsi_pkg::fbsi_top_s  n;

  //--------------------------------------------------------------------
  // bit-rate detection
  //--------------------------------------------------------------------
  fbsi_rate_detect u_rate (
    .core_clk_in     (core_clk_in),
    .rst_in          (rst_in),
    .bus_rx_in       (bus_rx_in),
    .rate_idx_out    (rate_idx_out),
    .rate_locked_out (rate_locked_out)
  );

  //--------------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------------
  function automatic logic len_bad(input logic [7:0] len,
                                   input logic [7:0] lim);
    return len > lim;
  endfunction

  function automatic logic [31:0] pack_len(input logic [7:0] in_len,
                                           input logic [7:0] out_len);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`FBSI_LEN_IN_LSB +: 8]  = in_len;
    w[`FBSI_LEN_OUT_LSB +: 8] = out_len;
    return w;
  endfunction

  //--------------------------------------------------------------------
  // next state
  //--------------------------------------------------------------------
  always_comb begin
    logic [7:0]          eff_lim;
    logic [6:0]          bin;
    logic                digits_ok;
    logic [24:0]         half;
    logic [31:0]         st;
    fbsi_pkg::fbsi_mode_e nm;
    eff_lim   = 8'h00;
    bin       = 7'h00;
    digits_ok = 1'b0;
    half      = 25'h000_0000;
    st        = 32'h0000_0000;
    nm        = fbsi_pkg::FBSI_M_IDLE;
    n         = s;

    // pins pass two flip-flops before use
    n.act_s1 = bus_active_in;
    n.act_s2 = s.act_s1;
    n.sw_s1  = {sw_tens_in, sw_ones_in};
    n.sw_s2  = s.sw_s1;

    // register writes; unmapped addresses are ignored
    if (wr_stb_in) begin
      case (addr_in)
        `FBSI_REG_CTRL: begin
          n.exch_en = wr_data_in[`FBSI_CTRL_EXCH];
        end
        `FBSI_REG_LOC_LEN: begin
          n.loc_in  = wr_data_in[`FBSI_LEN_IN_LSB +: 8];
          n.loc_out = wr_data_in[`FBSI_LEN_OUT_LSB +: 8];
        end
        `FBSI_REG_MST_LEN: begin
          n.mst_in  = wr_data_in[`FBSI_LEN_IN_LSB +: 8];
          n.mst_out = wr_data_in[`FBSI_LEN_OUT_LSB +: 8];
        end
        `FBSI_REG_LOC_PRM: begin
          n.loc_prm = wr_data_in[15:0];
        end
        `FBSI_REG_MST_PRM: begin
          n.mst_prm = wr_data_in[15:0];
        end
        `FBSI_REG_LIMIT: begin
          n.limit = wr_data_in[7:0];
        end
        default: begin
        end
      endcase
    end

    // R7: decimal switch decode
    digits_ok    = (s.sw_s2[7:4] <= `FBSI_DIGIT_MAX) &&
                   (s.sw_s2[3:0] <= `FBSI_DIGIT_MAX);
    bin          = 7'({3'h0, s.sw_s2[7:4]} * 7'h0a) + {3'h0, s.sw_s2[3:0]};
    n.station    = digits_ok ? bin : 7'h00;
    n.addr_valid = digits_ok && (bin >= `FBSI_ADDR_MIN) &&
                   (bin <= `FBSI_ADDR_MAX);

    // R8: master may only lower the byte ceiling
    eff_lim   = (s.limit < MAX_BYTES) ? s.limit : MAX_BYTES;
    // R4: length mismatch or oversize is a configuration error
    n.cfg_err = (s.loc_in != s.mst_in) || (s.loc_out != s.mst_out) ||
                len_bad(s.loc_in, eff_lim) || len_bad(s.loc_out, eff_lim);
    // R5: parameter signature compare
    n.prm_err = (s.loc_prm != s.mst_prm);

    // R1: exchange possible only with everything agreed
    n.online  = s.act_s2 && s.exch_en && s.addr_valid &&
                rate_locked_out && !s.cfg_err && !s.prm_err;
    // R2: off-line is exactly not on-line
    n.offline = !n.online;

    // R9: configuration error takes priority
    if (s.cfg_err) begin
      nm = fbsi_pkg::FBSI_M_CFG;
    end else if (s.prm_err) begin
      nm = fbsi_pkg::FBSI_M_PRM;
    end else begin
      nm = fbsi_pkg::FBSI_M_IDLE;
    end
    half = (nm == fbsi_pkg::FBSI_M_CFG) ? 25'(HALF_1HZ_CYC - 1) :
                                          25'(HALF_2HZ_CYC - 1);

    // a change of fault restarts the blink lit, so it shows at once
    if (nm != s.mode) begin
      n.mode = nm;
      n.cnt  = 25'h000_0000;
      n.diag = (nm != fbsi_pkg::FBSI_M_IDLE);
    end else begin
      case (s.mode)
        // R3: dark without fault
        fbsi_pkg::FBSI_M_IDLE: begin
          n.cnt  = 25'h000_0000;
          n.diag = 1'b0;
        end
        // R4: blink at 1 Hz
        fbsi_pkg::FBSI_M_CFG,
        // R5: blink at 2 Hz
        fbsi_pkg::FBSI_M_PRM: begin
          if (s.cnt >= half) begin
            n.cnt  = 25'h000_0000;
            n.diag = !s.diag;
          end else begin
            n.cnt  = s.cnt + 25'h000_0001;
          end
        end
        default: begin
          n.mode = fbsi_pkg::FBSI_M_IDLE;
          n.cnt  = 25'h000_0000;
          n.diag = 1'b0;
        end
      endcase
    end

    // register reads: data only in the cycle after the strobe
    st[`FBSI_ST_ONLINE]         = s.online;
    st[`FBSI_ST_OFFLINE]        = s.offline;
    st[`FBSI_ST_DIAG]           = s.diag;
    st[`FBSI_ST_CFG_ERR]        = s.cfg_err;
    st[`FBSI_ST_PRM_ERR]        = s.prm_err;
    st[`FBSI_ST_ADDR_OK]        = s.addr_valid;
    st[`FBSI_ST_LOCKED]         = rate_locked_out;
    st[`FBSI_ST_RATE_LSB +: 4]  = rate_idx_out;
    st[`FBSI_ST_ADDR_LSB +: 7]  = s.station;
    n.rdata = 32'h0000_0000;
    if (rd_stb_in) begin
      case (addr_in)
        `FBSI_REG_CTRL:    n.rdata = {31'h0000_0000, s.exch_en};
        `FBSI_REG_LOC_LEN: n.rdata = pack_len(s.loc_in, s.loc_out);
        `FBSI_REG_MST_LEN: n.rdata = pack_len(s.mst_in, s.mst_out);
        `FBSI_REG_LOC_PRM: n.rdata = {16'h0000, s.loc_prm};
        `FBSI_REG_MST_PRM: n.rdata = {16'h0000, s.mst_prm};
        `FBSI_REG_LIMIT:   n.rdata = {24'h00_0000, s.limit};
        `FBSI_REG_STATUS:  n.rdata = st;
        default:           n.rdata = 32'h0000_0000;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // state register
  //--------------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '{act_s1: 1'b0, act_s2: 1'b0, sw_s1: 8'h00, sw_s2: 8'h00,
             exch_en: 1'b0, loc_in: 8'h00, loc_out: 8'h00,
             mst_in: 8'h00, mst_out: 8'h00, loc_prm: 16'h0000,
             mst_prm: 16'h0000, limit: `FBSI_RST_LIMIT,
             cfg_err: 1'b0, prm_err: 1'b0, addr_valid: 1'b0,
             station: 7'h00, online: 1'b0, offline: 1'b1,
             mode: fbsi_pkg::FBSI_M_IDLE, cnt: 25'h000_0000,
             diag: 1'b0, rdata: 32'h0000_0000};
    end else begin
      s <= n;
    end
  end

  assign rd_data_out      = s.rdata;
  assign online_led_out   = s.online;
  assign offline_led_out  = s.offline;
  assign diag_led_out     = s.diag;
  assign station_addr_out = s.station;
  assign addr_valid_out   = s.addr_valid;

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------
  property p_online_cause;
    @(posedge core_clk_in) disable iff (rst_in)
    online_led_out |-> ($past(s.exch_en) && $past(s.act_s2) &&
                        !$past(s.cfg_err) && !$past(s.prm_err));
  endproperty
  a_online_cause: assert property (p_online_cause) // R1
    else $error("on-line lamp lit without exchange conditions");

  property p_offline_excl;
    @(posedge core_clk_in) disable iff (rst_in)
    offline_led_out != online_led_out;
  endproperty
  a_offline_excl: assert property (p_offline_excl) // R2
    else $error("off-line lamp not the inverse of on-line lamp");

  property p_diag_dark;
    @(posedge core_clk_in) disable iff (rst_in)
    (!s.cfg_err && !s.prm_err) |=> !diag_led_out;
  endproperty
  a_diag_dark: assert property (p_diag_dark) // R3
    else $error("diagnostics lamp lit with no fault");

  property p_blink_1hz;
    @(posedge core_clk_in) disable iff (rst_in)
    (s.mode == fbsi_pkg::FBSI_M_CFG && s.cfg_err &&
     s.cnt == 25'(HALF_1HZ_CYC - 1))
      |=> (diag_led_out != $past(diag_led_out) && s.cnt == 25'h0);
  endproperty
  a_blink_1hz: assert property (p_blink_1hz) // R4
    else $error("length error lamp did not toggle at half period");

  property p_blink_2hz;
    @(posedge core_clk_in) disable iff (rst_in)
    (s.mode == fbsi_pkg::FBSI_M_PRM && s.prm_err && !s.cfg_err &&
     s.cnt == 25'(HALF_2HZ_CYC - 1))
      |=> (diag_led_out != $past(diag_led_out) && s.cnt == 25'h0);
  endproperty
  a_blink_2hz: assert property (p_blink_2hz) // R5
    else $error("parameter error lamp did not toggle at half period");

  property p_addr_gate;
    @(posedge core_clk_in) disable iff (rst_in)
    (!s.addr_valid || station_addr_out > 7'h63) |=> !online_led_out;
  endproperty
  a_addr_gate: assert property (p_addr_gate) // R7
    else $error("on-line with an invalid station address");

  property p_len_limit;
    @(posedge core_clk_in) disable iff (rst_in)
    (s.loc_in > MAX_BYTES || s.loc_out > MAX_BYTES) |-> ##2 !online_led_out;
  endproperty
  a_len_limit: assert property (p_len_limit) // R8
    else $error("on-line with process data over the byte ceiling");

  property p_cfg_first;
    @(posedge core_clk_in) disable iff (rst_in)
    (s.cfg_err && s.prm_err) |=> (s.mode == fbsi_pkg::FBSI_M_CFG);
  endproperty
  a_cfg_first: assert property (p_cfg_first) // R9
    else $error("parameter blink shown over a length error");

endmodule // fbsi_top

// ===== dv/fbsi_master_model.sv
// fbsi_master_model.sv: behavioural fieldbus master driving the bus pins
`timescale 1ns/100ps
module fbsi_master_model (
  input  wire logic       core_clk_in,   // bench clock
  input  wire logic       attach_in,     // master addresses this slave
  input  wire logic       run_in,        // send a bit pattern
  input  wire logic [9:0] low_cyc_in,    // low and high time, cycles
  output logic            active_out,    // master talks to the slave
  output logic            rx_out         // bus receive line
);
  initial begin
    rx_out     = 1'b1;
    active_out = 1'b0;
  end

  always @(posedge core_clk_in) begin
    active_out <= attach_in;
  end

  //--------------------------------------------------------------------
  // bit stream
  //--------------------------------------------------------------------
  // any bit rate whose bit time fits in low_cyc_in, up to 1023 cycles
  // line idles high between frames, as a released bus would
  always begin
    @(posedge core_clk_in);
    if (run_in) begin
      rx_out <= 1'b0;
      repeat (low_cyc_in) @(posedge core_clk_in);
      rx_out <= 1'b1;
      repeat (low_cyc_in - 1) @(posedge core_clk_in);
    end
  end
endmodule // fbsi_master_model

// ===== dv/fbsi_top_test.sv
// fbsi_top_test.sv: self-checking testbench of the status indicator block
`timescale 1ns/100ps
module fbsi_top_test;
  localparam int H1 = 8;
  localparam int H2 = 4;
  logic        core_clk, rst, act, rx, wr, rd, attach, run;
  logic [3:0]  tens, ones, band;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [9:0]  low_cyc;
  logic        online, offline, diag, addr_ok, locked;
  logic [6:0]  station;
  int          num_errors, n_checks;

  fbsi_master_model i_master (
    .core_clk_in(core_clk), .attach_in(attach), .run_in(run),
    .low_cyc_in(low_cyc), .active_out(act), .rx_out(rx));

  fbsi_top #(.HALF_1HZ_CYC(H1), .HALF_2HZ_CYC(H2)) i_dut (
    .core_clk_in(core_clk), .rst_in(rst), .bus_active_in(act),
    .bus_rx_in(rx), .sw_tens_in(tens), .sw_ones_in(ones),
    .addr_in(addr), .wr_data_in(wdata), .wr_stb_in(wr), .rd_stb_in(rd),
    .rd_data_out(rdata), .online_led_out(online),
    .offline_led_out(offline), .diag_led_out(diag),
    .station_addr_out(station), .addr_valid_out(addr_ok),
    .rate_idx_out(band), .rate_locked_out(locked));

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  //--------------------------------------------------------------------
  // shared tasks
  //--------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    // hand back off the edge so callers never race the launched outputs
    #1;
  endtask

  // read data stand one cycle only, then fall back to zero
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    rd <= 1'b1; addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
    cyc(1);
    check(rdata, 32'h0000_0000);
  endtask

  task automatic run_len(input logic v, output int n);
    n = 0;
    while (diag === v && n < 2000) begin
      cyc(1);
      n++;
    end
  endtask

  // skip the partial phases, then time one whole lit and one dark phase
  task automatic blink(input int half);
    int n;
    run_len(1'b1, n);
    run_len(1'b0, n);
    run_len(1'b1, n);
    check(n, half);
    run_len(1'b0, n);
    check(n, half);
  endtask

  task automatic lamps(input logic on, input logic off);
    check({online, offline}, {on, off});
  endtask

  //--------------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------------
  task automatic t_reset;
    lamps(1'b0, 1'b1);
    check(diag, 1'b0);
    reg_rd(8'h14, 32'h0000_00c8);
    reg_rd(8'h08, 32'h0000_0000);
    reg_rd(8'h00, 32'h0000_0000);
  endtask

  task automatic t_addr;
    logic [3:0] tt [6] = '{4'h0, 4'h0, 4'h9, 4'h1, 4'ha, 4'h3};
    logic [3:0] oo [6] = '{4'h0, 4'h1, 4'h9, 4'h0, 4'h5, 4'hf};
    logic [6:0] st [6] = '{7'h00, 7'h01, 7'h63, 7'h0a, 7'h00, 7'h00};
    logic       ok [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      tens <= tt[i]; ones <= oo[i];
      cyc(5);
      check({addr_ok, station}, {ok[i], st[i]});
    end
    // leave a valid address for the on-line scenarios
    @(posedge core_clk);
    tens <= 4'h1; ones <= 4'h0;
    cyc(5);
    check({addr_ok, station}, {1'b1, 7'h0a});
  endtask

  task automatic t_rate;
    logic [9:0] lw [6] = '{10'd2, 10'd7, 10'd14, 10'd30, 10'd80, 10'd200};
    logic [3:0] bd [6] = '{4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4};
    check(locked, 1'b0);
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      low_cyc <= lw[i]; run <= 1'b1;
      cyc(64 * int'(lw[i]) + 8);
      check({locked, band}, {1'b1, bd[i]});
    end
  endtask

  task automatic t_online;
    reg_wr(8'h00, 32'h0000_0001);
    @(posedge core_clk);
    attach <= 1'b1;
    cyc(8);
    lamps(1'b1, 1'b0);
    check(diag, 1'b0);
    reg_rd(8'h18, 32'h000a_0461);
    reg_rd(8'h1c, 32'h0000_0000);
    reg_wr(8'h18, 32'h0000_0000);
    reg_rd(8'h18, 32'h000a_0461);
    @(posedge core_clk);
    attach <= 1'b0;
    cyc(6);
    lamps(1'b0, 1'b1);
    @(posedge core_clk);
    attach <= 1'b1;
    cyc(6);
    lamps(1'b1, 1'b0);
  endtask

  task automatic t_faults;
    reg_wr(8'h08, 32'h0000_0102);
    cyc(4);
    check(diag, 1'b1);
    blink(H1);
    lamps(1'b0, 1'b1);
    reg_rd(8'h18, 32'h000a_046e);
    reg_wr(8'h08, 32'h0000_0000);
    reg_wr(8'h10, 32'h0000_1234);
    blink(H2);
    reg_wr(8'h08, 32'h0000_0102);
    cyc(4);
    blink(H1);
    reg_wr(8'h08, 32'h0000_0000);
    reg_wr(8'h0c, 32'h0000_1234);
    cyc(5);
    for (int i = 0; i < 20; i++) begin
      check(diag, 1'b0);
      cyc(1);
    end
    lamps(1'b1, 1'b0);
    reg_rd(8'h0c, 32'h0000_1234);
    reg_rd(8'h10, 32'h0000_1234);
  endtask

  // lengths above the byte limit count as configuration errors
  task automatic t_limit;
    reg_wr(8'h14, 32'h0000_00ff);
    reg_wr(8'h04, 32'h0000_c8c8);
    reg_wr(8'h08, 32'h0000_c8c8);
    cyc(5);
    lamps(1'b1, 1'b0);
    reg_wr(8'h04, 32'h0000_c8c9);
    reg_wr(8'h08, 32'h0000_c8c9);
    cyc(5);
    lamps(1'b0, 1'b1);
    blink(H1);
    reg_wr(8'h14, 32'h0000_0010);
    reg_wr(8'h04, 32'h0000_1010);
    reg_wr(8'h08, 32'h0000_1010);
    cyc(5);
    lamps(1'b1, 1'b0);
    reg_wr(8'h04, 32'h0000_1110);
    reg_wr(8'h08, 32'h0000_1110);
    cyc(5);
    lamps(1'b0, 1'b1);
    reg_rd(8'h04, 32'h0000_1110);
  endtask

  //--------------------------------------------------------------------
  // run control
  //--------------------------------------------------------------------
  task automatic test_done;
    $display("errors=%0d checks=%0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #2_500_000;
    num_errors++;
    test_done;
  end

  initial begin
    num_errors = 0; n_checks = 0;
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = '0;
    tens = 4'h0; ones = 4'h0; attach = 1'b0; run = 1'b0;
    low_cyc = 10'd2;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    cyc(1);
    t_reset;
    t_addr;
    t_rate;
    t_online;
    t_faults;
    t_limit;
    test_done;
  end
endmodule // fbsi_top_test
